// *** hw/standby_pkg.sv ***
// Notes on behaviour
// - halt with standby_select set moves the device from run into standby.
// - standby stops system clock, CPU clock and all peripheral clocks.
// - CPU registers and RAM are held unchanged for the whole of standby.
// - in standby the port pins either hold state or float.
// - interrupt, break, cache, bus, pin units, ports, standby register kept.
// - standby entry resets transfer controller, except its data register.
// - standby resets DMA control regs; address and count regs undefined.
// - standby resets the pulse timer; output-disable unit keeps contents.
// - standby clears watchdog bits 7..5, reset status; keeps select, counter.
// - standby initialises all serial unit registers.
// - standby initialises analog converter and compare-match unit registers.
// - standby ends only on interrupt pin edge, power-on or manual reset.
// - selected interrupt pin edge in standby restarts the oscillator.
// - after restart only the watchdog is clocked until it overflows.
// - watchdog overflow clocks the whole chip and starts nmi processing.
// - power-on reset pin low cancels standby.
// - edge_polarity_select 0 picks falling edge, 1 picks rising edge.
// - standby_select cannot be set while wdt_run_enable is 1.
// - port_float_select 1 floats pins in standby, 0 holds them.
// - standby_control_reg resets to 1F with both control bits clear.
package standby_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [4:0] STANDBY_CTRL_OFS = 5'h00;
  localparam logic [4:0] IRQ_CTRL_OFS = 5'h04;
  localparam logic [4:0] WDT_CTRL_OFS = 5'h08;
  localparam logic [4:0] WDT_COUNT_OFS = 5'h0C;
  localparam logic [4:0] WDT_RST_STAT_OFS = 5'h10;
  localparam logic [4:0] POWER_STAT_OFS = 5'h14;

  // standby_control_reg fields and reset value
  localparam int SBY_BIT = 7;
  localparam int HIZ_BIT = 6;
  localparam logic [7:0] STANDBY_CTRL_RESET = 8'h1F;
  localparam logic [5:0] STANDBY_CTRL_FIXED = 6'h1F;

  // irq_control_reg field
  localparam int EDGE_SEL_BIT = 0;

  // wdt_control_status_reg fields
  localparam int WDT_OVF_BIT = 7;
  localparam int WDT_MODE_BIT = 6;
  localparam int WDT_RUN_BIT = 5;
  localparam int WDT_CKS_LSB = 0;
  localparam int WDT_CKS_W = 3;
  localparam logic [2:0] WDT_CKS_RESET = 3'h0;
  localparam logic [7:0] WDT_COUNT_RESET = 8'h00;

  // wdt_reset_status_reg field
  localparam int WDT_RST_FLAG_BIT = 7;

  // peripheral initialise strobe layout
  localparam int INIT_W = 6;
  localparam int INIT_XFER = 0;
  localparam int INIT_DMA = 1;
  localparam int INIT_PULSE_TMR = 2;
  localparam int INIT_SERIAL = 3;
  localparam int INIT_ANALOG = 4;
  localparam int INIT_CMP_TMR = 5;

  typedef enum logic [1:0] {
    RUN_ST,
    SLEEP_ST,
    STANDBY_ST,
    OSC_WAKE_ST
  } power_type;

endpackage : standby_pkg

// *** hw/pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk, // block clock
  input wire logic rst, // synchronous reset
  input wire logic pin, // asynchronous pin level
  output logic level // level after two flops
);

  typedef struct packed {
    logic first;
    logic second;
  } sync_type;

  sync_type q;
  sync_type d;

  always_comb begin
    d.first = pin;
    d.second = q.first;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{first: RESET_VAL, second: RESET_VAL};
    end else begin
      q <= d;
    end
  end

  assign level = q.second;

endmodule : pin_sync

// *** hw/standby_mode_control.sv ***
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module standby_mode_control
  import standby_pkg::*;
#(
  parameter int PRESC_W = 16
) (
  input wire logic CLK, // 10 MHz always-on clock
  input wire logic RST, // synchronous reset, active high
  input wire logic [standby_pkg::ADDR_W-1:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [standby_pkg::DATA_W-1:0] AVS_WRITEDATA, // write data
  input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
  output logic [standby_pkg::DATA_W-1:0] AVS_READDATA, // read data
  output logic AVS_WAITREQUEST, // stall, low marks the answer
  input wire logic HALT_EXEC, // cpu executes halt, one-cycle pulse
  input wire logic IRQ_IN, // maskable interrupt request
  input wire logic ADDR_ERR, // transfer address error event
  input wire logic NMI_PIN, // non-maskable interrupt pin
  input wire logic POWER_ON_RESET_PIN_N, // power-on reset pin, low active
  input wire logic MANUAL_RESET_PIN_N, // manual reset pin, low active
  output logic SYS_CLK_EN, // system clock running
  output logic CPU_CLK_EN, // cpu clock running
  output logic PERIPH_CLK_EN, // peripheral clocks running
  output logic WDT_CLK_EN, // watchdog clock running
  output logic OSC_EN, // oscillator enabled
  output logic RETAIN, // cpu registers and ram held
  output logic PORT_FLOAT, // ports high impedance
  output logic PORT_HOLD, // ports latched
  output logic [standby_pkg::INIT_W-1:0] INIT_MODULES, // init strobes
  output logic DMA_ADDR_UNDEF, // dma address/count lose meaning
  output logic IRQ_TO_CPU, // gated maskable interrupt
  output logic NMI_EXC, // start nmi exception, pulse
  output logic MANUAL_RESET_PIN_EXC // start manual reset processing, pulse
);

  import standby_pkg::*;

  if (PRESC_W < 16 || PRESC_W > 24) begin : g_bad_presc
    $error("PRESC_W must lie in 16..24");
  end

  typedef struct packed {
    power_type st;
    logic wait_req;
    logic [DATA_W-1:0] rdata;
    logic standby_select;
    logic port_float_select;
    logic edge_polarity_select;
    logic ovf;
    logic wdt_mode;
    logic wdt_run;
    logic [WDT_CKS_W-1:0] cks;
    logic [7:0] cnt;
    logic [PRESC_W-1:0] presc;
    logic rst_flag;
    logic nmi_prev;
    logic manual_reset_pin_prev;
    logic sys_clk;
    logic cpu_clk;
    logic periph_clk;
    logic wdt_clk;
    logic osc;
    logic retain;
    logic port_float;
    logic port_hold;
    logic [INIT_W-1:0] init_mod;
    logic dma_undef;
    logic irq_out;
    logic nmi_exc;
    logic manual_reset_pin_exc;
  } state_type;

  localparam state_type STATE_RESET = '{
    st: RUN_ST,
    wait_req: 1'b1,
    rdata: '0,
    standby_select: STANDBY_CTRL_RESET[SBY_BIT],
    port_float_select: STANDBY_CTRL_RESET[HIZ_BIT],
    edge_polarity_select: 1'b0,
    ovf: 1'b0,
    wdt_mode: 1'b0,
    wdt_run: 1'b0,
    cks: WDT_CKS_RESET,
    cnt: WDT_COUNT_RESET,
    presc: '0,
    rst_flag: 1'b0,
    nmi_prev: 1'b0,
    manual_reset_pin_prev: 1'b1,
    sys_clk: 1'b1,
    cpu_clk: 1'b1,
    periph_clk: 1'b1,
    wdt_clk: 1'b1,
    osc: 1'b1,
    retain: 1'b0,
    port_float: 1'b0,
    port_hold: 1'b0,
    init_mod: '0,
    dma_undef: 1'b0,
    irq_out: 1'b0,
    nmi_exc: 1'b0,
    manual_reset_pin_exc: 1'b0
  };

  state_type q;
  state_type d;
  logic nmi_s;
  logic por_n_s;
  logic manual_reset_pin_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  pin_sync #(.RESET_VAL(1'b0)) nmi_sync (
    .clk(CLK),
    .rst(RST),
    .pin(NMI_PIN),
    .level(nmi_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) por_sync (
    .clk(CLK),
    .rst(RST),
    .pin(POWER_ON_RESET_PIN_N),
    .level(por_n_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) manual_reset_pin_sync (
    .clk(CLK),
    .rst(RST),
    .pin(MANUAL_RESET_PIN_N),
    .level(manual_reset_pin_n_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic nmi_edge;
    logic manual_reset_pin_fall;
    logic wr;
    logic [PRESC_W-1:0] mask;
    logic tick;
    logic overflow;
    logic count_on;
    logic [DATA_W-1:0] rd;
    nmi_edge = 1'b0;
    manual_reset_pin_fall = 1'b0;
    wr = 1'b0;
    mask = '0;
    tick = 1'b0;
    overflow = 1'b0;
    count_on = 1'b0;
    rd = '0;
    d = q;
    d.init_mod = '0;
    d.dma_undef = 1'b0;
    d.nmi_exc = 1'b0;
    d.manual_reset_pin_exc = 1'b0;
    d.nmi_prev = nmi_s;
    d.manual_reset_pin_prev = manual_reset_pin_n_s;
    // the mark bit picks which transition of the pin counts
    nmi_edge = q.edge_polarity_select ? (nmi_s & ~q.nmi_prev)
                      : (~nmi_s & q.nmi_prev);
    manual_reset_pin_fall = q.manual_reset_pin_prev & ~manual_reset_pin_n_s;
    wr = AVS_WRITE & ~q.wait_req & AVS_BYTEENABLE[0];

    // read mux, unmapped offsets read zero
    case (AVS_ADDRESS)
      STANDBY_CTRL_OFS: begin
        rd[7:0] = {q.standby_select, q.port_float_select, STANDBY_CTRL_FIXED};
      end
      IRQ_CTRL_OFS: begin
        rd[EDGE_SEL_BIT] = q.edge_polarity_select;
      end
      WDT_CTRL_OFS: begin
        rd[WDT_OVF_BIT] = q.ovf;
        rd[WDT_MODE_BIT] = q.wdt_mode;
        rd[WDT_RUN_BIT] = q.wdt_run;
        rd[WDT_CKS_LSB +: WDT_CKS_W] = q.cks;
      end
      WDT_COUNT_OFS: begin
        rd[7:0] = q.cnt;
      end
      WDT_RST_STAT_OFS: begin
        rd[WDT_RST_FLAG_BIT] = q.rst_flag;
      end
      POWER_STAT_OFS: begin
        rd[1:0] = q.st;
      end
      default: begin
        rd = '0;
      end
    endcase

    // one wait cycle, then the answer stands for exactly one cycle
    if (q.wait_req && (AVS_READ || AVS_WRITE)) begin
      d.wait_req = 1'b0;
      d.rdata = rd;
    end else begin
      d.wait_req = 1'b1;
    end

    // register writes take effect at the edge with waitrequest low
    if (wr) begin
      case (AVS_ADDRESS)
        STANDBY_CTRL_OFS: begin
          // a running watchdog blocks setting either control bit
          if (q.wdt_run) begin
            d.standby_select = q.standby_select & AVS_WRITEDATA[SBY_BIT];
            d.port_float_select = q.port_float_select & AVS_WRITEDATA[HIZ_BIT];
          end else begin
            d.standby_select = AVS_WRITEDATA[SBY_BIT];
            d.port_float_select = AVS_WRITEDATA[HIZ_BIT];
          end
        end
        IRQ_CTRL_OFS: begin
          d.edge_polarity_select = AVS_WRITEDATA[EDGE_SEL_BIT];
        end
        WDT_CTRL_OFS: begin
          // overflow flag is clear-only from software
          d.ovf = q.ovf & AVS_WRITEDATA[WDT_OVF_BIT];
          d.wdt_mode = AVS_WRITEDATA[WDT_MODE_BIT];
          d.wdt_run = AVS_WRITEDATA[WDT_RUN_BIT];
          d.cks = AVS_WRITEDATA[WDT_CKS_LSB +: WDT_CKS_W];
        end
        WDT_COUNT_OFS: begin
          d.cnt = AVS_WRITEDATA[7:0];
        end
        WDT_RST_STAT_OFS: begin
          d.rst_flag = q.rst_flag & AVS_WRITEDATA[WDT_RST_FLAG_BIT];
        end
        default: begin
        end
      endcase
    end

    // watchdog prescaler: divide by 2^(2*cks+1)
    mask = PRESC_W'((32'd1 << (2 * int'(q.cks) + 1)) - 32'd1);
    tick = &(q.presc | ~mask);
    count_on = (q.st == OSC_WAKE_ST) || (q.wdt_run && q.st != STANDBY_ST);
    overflow = count_on && tick && (q.cnt == 8'hFF);
    if (count_on) begin
      d.presc = q.presc + PRESC_W'(1);
      if (tick) begin
        d.cnt = q.cnt + 8'h01;
      end
    end
    // hardware set wins over a software clear in the same cycle
    if (overflow && q.st != OSC_WAKE_ST) begin
      d.ovf = 1'b1;
      if (q.wdt_mode) begin
        d.rst_flag = 1'b1;
      end
    end

    case (q.st)
      RUN_ST: begin
        if (nmi_edge) begin
          d.nmi_exc = 1'b1;
        end
        if (HALT_EXEC && q.standby_select) begin
          d.st = STANDBY_ST;
          d.init_mod[INIT_XFER] = 1'b1;
          d.init_mod[INIT_DMA] = 1'b1;
          d.dma_undef = 1'b1;
          d.init_mod[INIT_PULSE_TMR] = 1'b1;
          d.init_mod[INIT_SERIAL] = 1'b1;
          d.init_mod[INIT_ANALOG] = 1'b1;
          d.init_mod[INIT_CMP_TMR] = 1'b1;
          // select bits and counter are left alone
          d.ovf = 1'b0;
          d.wdt_mode = 1'b0;
          d.wdt_run = 1'b0;
          d.rst_flag = 1'b0;
          d.presc = '0;
        end else if (HALT_EXEC) begin
          d.st = SLEEP_ST;
        end
      end
      SLEEP_ST: begin
        if (nmi_edge) begin
          d.st = RUN_ST;
          d.nmi_exc = 1'b1;
        end else if (IRQ_IN || ADDR_ERR) begin
          d.st = RUN_ST;
        end
      end
      STANDBY_ST: begin
        // other events are not looked at here
        if (nmi_edge) begin
          d.st = OSC_WAKE_ST;
          d.presc = '0;
        end
      end
      OSC_WAKE_ST: begin
        if (overflow) begin
          d.st = RUN_ST;
          d.nmi_exc = 1'b1;
        end
      end
      default: begin
        d.st = RUN_ST;
      end
    endcase

    // manual reset leaves any low-power state
    if (manual_reset_pin_fall) begin
      d.st = RUN_ST;
      d.manual_reset_pin_exc = 1'b1;
    end

    // output levels follow the state being entered
    d.sys_clk = (d.st == RUN_ST) || (d.st == SLEEP_ST);
    d.cpu_clk = (d.st == RUN_ST);
    d.periph_clk = d.sys_clk;
    d.wdt_clk = d.sys_clk || (d.st == OSC_WAKE_ST);
    d.osc = (d.st != STANDBY_ST);
    // retained by stopping clocks rather than by touching state
    d.retain = (d.st == STANDBY_ST) || (d.st == OSC_WAKE_ST);
    d.port_float = d.retain && q.port_float_select;
    d.port_hold = d.retain && !q.port_float_select;
    d.irq_out = IRQ_IN && d.sys_clk;

    // power-on reset pin acts like a full reset, cancelling standby
    if (!por_n_s) begin
      d = STATE_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CLK) begin
    if (RST) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign AVS_READDATA = q.rdata;
  assign AVS_WAITREQUEST = q.wait_req;
  assign SYS_CLK_EN = q.sys_clk;
  assign CPU_CLK_EN = q.cpu_clk;
  assign PERIPH_CLK_EN = q.periph_clk;
  assign WDT_CLK_EN = q.wdt_clk;
  assign OSC_EN = q.osc;
  assign RETAIN = q.retain;
  assign PORT_FLOAT = q.port_float;
  assign PORT_HOLD = q.port_hold;
  assign INIT_MODULES = q.init_mod;
  assign DMA_ADDR_UNDEF = q.dma_undef;
  assign IRQ_TO_CPU = q.irq_out;
  assign NMI_EXC = q.nmi_exc;
  assign MANUAL_RESET_PIN_EXC = q.manual_reset_pin_exc;

endmodule : standby_mode_control

// *** test/standby_mode_control_sva.sv ***
`timescale 1ns/100ps
module standby_mode_control_sva (
  input wire logic CLK, // clock
  input wire logic RST, // reset
  input wire logic AVS_READ, // read
  input wire logic AVS_WRITE, // write
  input wire logic AVS_WAITREQUEST, // stall
  input wire logic POWER_ON_RESET_PIN_N, // power-on pin
  input wire logic SYS_CLK_EN, // system clock
  input wire logic CPU_CLK_EN, // cpu clock
  input wire logic PERIPH_CLK_EN, // peripheral clocks
  input wire logic WDT_CLK_EN, // watchdog clock
  input wire logic OSC_EN, // oscillator
  input wire logic RETAIN, // hold state
  input wire logic PORT_FLOAT, // ports float
  input wire logic PORT_HOLD, // ports held
  input wire logic [standby_pkg::INIT_W-1:0] INIT_MODULES, // init strobes
  input wire logic DMA_ADDR_UNDEF, // dma undefined
  input wire logic IRQ_TO_CPU, // gated interrupt
  input wire logic NMI_EXC, // nmi start
  input wire logic MANUAL_RESET_PIN_EXC // manual reset start
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  // a power-on pin glitch during wake must not look like a silent exit
  sequence s_wake_end;
    $rose(SYS_CLK_EN) && $past(OSC_EN) && $past(POWER_ON_RESET_PIN_N, 3);
  endsequence
  sequence s_por_low;
    !POWER_ON_RESET_PIN_N [*3];
  endsequence
  property p_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  property p_stop;
    RETAIN |-> !SYS_CLK_EN && !CPU_CLK_EN && !PERIPH_CLK_EN;
  endproperty
  property p_port;
    RETAIN == (PORT_FLOAT ^ PORT_HOLD);
  endproperty
  property p_entry;
    INIT_MODULES != 6'h00 |-> INIT_MODULES == 6'h3F && DMA_ADDR_UNDEF
      && RETAIN && !OSC_EN;
  endproperty
  property p_init_pulse;
    INIT_MODULES != 6'h00 |=> INIT_MODULES == 6'h00;
  endproperty
  property p_irq_gate;
    (!SYS_CLK_EN ##1 !SYS_CLK_EN) |-> !IRQ_TO_CPU;
  endproperty
  property p_wake;
    OSC_EN && !SYS_CLK_EN |-> WDT_CLK_EN && !CPU_CLK_EN && RETAIN;
  endproperty
  property p_exit;
    s_wake_end |-> NMI_EXC || MANUAL_RESET_PIN_EXC;
  endproperty
  property p_por;
    s_por_low |=> SYS_CLK_EN && OSC_EN && !RETAIN;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer after request");
  a_stop: assert property (p_stop) else $error("clock runs in standby");
  a_port: assert property (p_port) else $error("port state wrong");
  a_entry: assert property (p_entry) else $error("bad init");
  a_init_pulse: assert property (p_init_pulse) else $error("long init");
  a_irq_gate: assert property (p_irq_gate) else $error("irq leak");
  a_wake: assert property (p_wake) else $error("wake clocks wrong");
  a_exit: assert property (p_exit) else $error("exit without start");
  a_por: assert property (p_por) else $error("power-on no cancel");
endmodule : standby_mode_control_sva
bind standby_mode_control standby_mode_control_sva
  standby_mode_control_sva_inst (
  .CLK(CLK), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .POWER_ON_RESET_PIN_N(POWER_ON_RESET_PIN_N), .SYS_CLK_EN(SYS_CLK_EN),
  .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
  .WDT_CLK_EN(WDT_CLK_EN), .OSC_EN(OSC_EN), .RETAIN(RETAIN),
  .PORT_FLOAT(PORT_FLOAT), .PORT_HOLD(PORT_HOLD),
  .INIT_MODULES(INIT_MODULES), .DMA_ADDR_UNDEF(DMA_ADDR_UNDEF),
  .IRQ_TO_CPU(IRQ_TO_CPU), .NMI_EXC(NMI_EXC), .MANUAL_RESET_PIN_EXC(MANUAL_RESET_PIN_EXC));

// *** test/cpu_pin_model.sv ***
`timescale 1ns/100ps
module cpu_pin_model (
  input wire logic CLK, // block clock
  output logic HALT_EXEC, // halt pulse
  output logic NMI_PIN // interrupt pin level
);
  initial begin
    HALT_EXEC = 1'b0;
    NMI_PIN = 1'b0;
  end
  // one-cycle halt, launched right after an edge so it is sampled once
  task automatic halt();
    @(posedge CLK);
    HALT_EXEC <= 1'b1;
    @(posedge CLK);
    HALT_EXEC <= 1'b0;
  endtask : halt
  // callers move the pin only during standby, to wake it, so the level at entry
  // is always the opposite of the selected wake edge
  task automatic set_nmi(input logic lvl);
    @(posedge CLK);
    NMI_PIN <= lvl;
  endtask : set_nmi
endmodule : cpu_pin_model

// *** test/standby_mode_control_tb.sv ***
`timescale 1ns/100ps
module standby_mode_control_tb;
  import standby_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic AVS_READ = 1'b0, AVS_WRITE = 1'b0, IRQ_IN = 1'b0, ADDR_ERR = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic POWER_ON_RESET_PIN_N = 1'b1, MANUAL_RESET_PIN_N = 1'b1;
  logic AVS_WAITREQUEST, HALT_EXEC, NMI_PIN, SYS_CLK_EN, CPU_CLK_EN;
  logic PERIPH_CLK_EN, WDT_CLK_EN, OSC_EN, RETAIN, PORT_FLOAT, PORT_HOLD;
  logic DMA_ADDR_UNDEF, IRQ_TO_CPU, NMI_EXC, MANUAL_RESET_PIN_EXC;
  logic [5:0] INIT_MODULES, init_seen = 6'h00;
  logic undef_seen = 1'b0;
  logic [31:0] q;
  int n_mismatch = 0, comparisons = 0, cyc = 0, k;
  always #50 CLK = ~CLK;
  standby_mode_control #(.PRESC_W(16)) standby_mode_control_inst (
    .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .HALT_EXEC(HALT_EXEC),
    .IRQ_IN(IRQ_IN), .ADDR_ERR(ADDR_ERR), .NMI_PIN(NMI_PIN),
    .POWER_ON_RESET_PIN_N(POWER_ON_RESET_PIN_N),
    .MANUAL_RESET_PIN_N(MANUAL_RESET_PIN_N), .SYS_CLK_EN(SYS_CLK_EN),
    .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .WDT_CLK_EN(WDT_CLK_EN), .OSC_EN(OSC_EN), .RETAIN(RETAIN),
    .PORT_FLOAT(PORT_FLOAT), .PORT_HOLD(PORT_HOLD),
    .INIT_MODULES(INIT_MODULES), .DMA_ADDR_UNDEF(DMA_ADDR_UNDEF),
    .IRQ_TO_CPU(IRQ_TO_CPU), .NMI_EXC(NMI_EXC), .MANUAL_RESET_PIN_EXC(MANUAL_RESET_PIN_EXC));
  cpu_pin_model cpu_pin_model_inst (.CLK(CLK), .HALT_EXEC(HALT_EXEC),
    .NMI_PIN(NMI_PIN));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // init strobes last one cycle, so they are caught here for later checks
  always @(posedge CLK) begin
    cyc++;
    if (INIT_MODULES !== 6'h00) init_seen <= INIT_MODULES;
    if (DMA_ADDR_UNDEF === 1'b1) undef_seen <= 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d}, 4'hF);
  endtask : wr
  task automatic rdc(input string what, input logic [4:0] a,
                     input logic [7:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    check(what, q, {24'h00_0000, e});
  endtask : rdc
  task automatic enter(input logic [7:0] ctrl);
    wr(STANDBY_CTRL_OFS, ctrl);
    cpu_pin_model_inst.halt();
    repeat (3) @(posedge CLK);
  endtask : enter
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    rdc("ctrl", STANDBY_CTRL_OFS, 8'h1F);
    rdc("unmapped", 5'h18, 8'h00);
    wr(STANDBY_CTRL_OFS, 8'h00);
    rdc("ctrl", STANDBY_CTRL_OFS, 8'h1F);
    bus(1'b1, STANDBY_CTRL_OFS, 32'h0000_00DF, 4'h0);
    rdc("ctrl", STANDBY_CTRL_OFS, 8'h1F);
    wr(WDT_CTRL_OFS, 8'h21);
    wr(STANDBY_CTRL_OFS, 8'hDF);
    rdc("ctrl", STANDBY_CTRL_OFS, 8'h1F);
    // overflow once in run so that entry has flags to clear
    wr(WDT_CTRL_OFS, 8'h01);
    wr(WDT_COUNT_OFS, 8'hFF);
    wr(WDT_CTRL_OFS, 8'h61);
    repeat (10) @(posedge CLK);
    rdc("wdt run", WDT_CTRL_OFS, 8'hE1);
    rdc("rstat run", WDT_RST_STAT_OFS, 8'h80);
    // eight cycles a tick for 16 ticks outlasts the modelled settling time
    wr(WDT_CTRL_OFS, 8'h81);
    wr(WDT_COUNT_OFS, 8'hF0);
    wr(IRQ_CTRL_OFS, 8'h01);
    enter(8'hDF);
    check("float", {PORT_FLOAT, PORT_HOLD}, 2'h2);
    check("clocks", {SYS_CLK_EN, CPU_CLK_EN}, 2'h0);
    check("periph", {PERIPH_CLK_EN, OSC_EN}, 2'h0);
    check("init", init_seen, 6'h3F);
    check("undef", undef_seen, 1'b1);
    rdc("state", POWER_STAT_OFS, 8'h02);
    rdc("wdt", WDT_CTRL_OFS, 8'h01);
    rdc("rstat", WDT_RST_STAT_OFS, 8'h00);
    rdc("count", WDT_COUNT_OFS, 8'hF0);
    rdc("ctrl", STANDBY_CTRL_OFS, 8'hDF);
    rdc("edge", IRQ_CTRL_OFS, 8'h01);
    IRQ_IN <= 1'b1;
    ADDR_ERR <= 1'b1;
    cpu_pin_model_inst.halt();
    repeat (3) @(posedge CLK);
    check("irq", IRQ_TO_CPU, 1'b0);
    rdc("state", POWER_STAT_OFS, 8'h02);
    IRQ_IN <= 1'b0;
    ADDR_ERR <= 1'b0;
    cpu_pin_model_inst.set_nmi(1'b1);
    k = 0;
    while (NMI_EXC !== 1'b1 && k < 300) begin
      @(posedge CLK);
      k++;
      if (k == 20) begin
        check("wake", {SYS_CLK_EN, WDT_CLK_EN, OSC_EN}, 3'h3);
      end
    end
    // 16 ticks of 8 cycles plus the pin synchroniser
    check("ovf time", (k >= 128 && k <= 136), 1'b1);
    repeat (2) @(posedge CLK);
    check("run", {SYS_CLK_EN, RETAIN}, 2'h2);
    rdc("state", POWER_STAT_OFS, 8'h00);
    wr(IRQ_CTRL_OFS, 8'h00);
    enter(8'h9F);
    check("hold", {PORT_FLOAT, PORT_HOLD}, 2'h1);
    MANUAL_RESET_PIN_N <= 1'b0;
    k = 0;
    while (MANUAL_RESET_PIN_EXC !== 1'b1 && k < 20) begin
      @(posedge CLK);
      k++;
    end
    check("manual_reset_pin", k < 20, 1'b1);
    MANUAL_RESET_PIN_N <= 1'b1;
    rdc("state", POWER_STAT_OFS, 8'h00);
    enter(8'h9F);
    rdc("state", POWER_STAT_OFS, 8'h02);
    POWER_ON_RESET_PIN_N <= 1'b0;
    repeat (5) @(posedge CLK);
    POWER_ON_RESET_PIN_N <= 1'b1;
    repeat (5) @(posedge CLK);
    rdc("state", POWER_STAT_OFS, 8'h00);
    rdc("ctrl", STANDBY_CTRL_OFS, 8'h1F);
    // halt with the select bit clear only sleeps, and an interrupt wakes it
    cpu_pin_model_inst.halt();
    rdc("state", POWER_STAT_OFS, 8'h01);
    check("sleep", {SYS_CLK_EN, CPU_CLK_EN, RETAIN}, 3'h4);
    IRQ_IN <= 1'b1;
    repeat (2) @(posedge CLK);
    check("irq on", IRQ_TO_CPU, 1'b1);
    IRQ_IN <= 1'b0;
    rdc("state", POWER_STAT_OFS, 8'h00);
    final_report();
  end
endmodule : standby_mode_control_tb
